/* include/rmcs_defines.vh */
`ifndef RMCS_DEFINES_VH
`define RMCS_DEFINES_VH

// system clock in kHz
`define RMCS_CLK_KHZ 25000

// settle and check times in ms
`define RMCS_T_FIRST_MS 40
`define RMCS_T_CHAN_MS 20
`define RMCS_T_MODE_MS 5
`define RMCS_T_LOCK_MS 20
`define RMCS_T_RUN_MS 10

// derived cycle counts (least times, exact at 25 MHz)
`define RMCS_FIRST_CYC (`RMCS_T_FIRST_MS * `RMCS_CLK_KHZ)
`define RMCS_CHAN_CYC (`RMCS_T_CHAN_MS * `RMCS_CLK_KHZ)
`define RMCS_MODE_CYC (`RMCS_T_MODE_MS * `RMCS_CLK_KHZ)
`define RMCS_LOCK_CYC (`RMCS_T_LOCK_MS * `RMCS_CLK_KHZ)

// manchester line: 4800 bit/s gives at most a 4.8 kHz signal
`define RMCS_TX_BAUD 4800
`define RMCS_HALF_BIT_CYC ((`RMCS_CLK_KHZ * 1000 + 2 * `RMCS_TX_BAUD - 1) / (2 * `RMCS_TX_BAUD))

// synthesizer serial word
`define RMCS_PLL_BITS 24
`define RMCS_PLL_HALF_CYC 4

// counter widths
`define RMCS_CNT_W 20
`define RMCS_HB_W 12

`endif

/* sim/rmcs_ctrl_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module rmcs_ctrl_sva #(
  parameter FIRST_CYC = 1,
  parameter CHAN_CYC = 1,
  parameter MODE_CYC = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // user side
  input wire logic cmd_power_on,
  input wire logic cmd_power_off,
  input wire logic cmd_tx,
  input wire logic link_ready,
  input wire logic tx_active,
  // module pins
  input wire logic pwr_switch,
  input wire logic receive_select,
  input wire logic transmit_select,
  input wire logic tx_data_in,
  input wire logic pll_clk,
  input wire logic pll_data,
  input wire logic pll_latch_strobe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [20:0] lat_q, sel_q;
  logic [12:0] run_q;
  logic first_q, line_q;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      lat_q <= 21'h0;
      sel_q <= 21'h0;
      run_q <= 13'h0;
      first_q <= 1'b0;
      line_q <= 1'b0;
    end else begin
      lat_q <= pll_latch_strobe ? 21'h0 : lat_q + 21'h1;
      sel_q <= ($rose(receive_select) || $rose(transmit_select)) ? 21'h0 : sel_q + 21'h1;
      run_q <= (!tx_active || tx_data_in != line_q) ? 13'h0 : run_q + 13'h1;
      line_q <= tx_data_in;
      first_q <= $rose(pwr_switch) | (first_q & ~link_ready);
    end
  end
  sequence s_both_off;
    !receive_select && !transmit_select;
  endsequence
  sequence s_tx_settle;
    transmit_select && !link_ready;
  endsequence
  property p_excl;
    !(receive_select && transmit_select);
  endproperty
  a_excl: assert property (p_excl) else $error("both selects high");
  property p_pwr_on;
    !pwr_switch && cmd_power_on |=> pwr_switch && receive_select && !transmit_select;
  endproperty
  a_pwr_on: assert property (p_pwr_on) else $error("power-on pins wrong");
  property p_idle;
    !pwr_switch |-> !pll_clk && !pll_data && !pll_latch_strobe;
  endproperty
  a_idle: assert property (p_idle) else $error("pll lines driven unpowered");
  property p_quiet_tx;
    transmit_select |-> !pll_clk && !pll_latch_strobe;
  endproperty
  a_quiet_tx: assert property (p_quiet_tx) else $error("pll programmed in transmit");
  property p_serial;
    pll_clk |-> $stable(pll_data) && !pll_latch_strobe;
  endproperty
  a_serial: assert property (p_serial) else $error("pll data moved with clock high");
  property p_tx_seq;
    link_ready && receive_select && cmd_tx && !cmd_power_off |=> s_both_off ##1 s_tx_settle;
  endproperty
  a_tx_seq: assert property (p_tx_seq) else $error("transmit switch order wrong");
  property p_mode;
    $rose(link_ready) |-> sel_q >= MODE_CYC - 1;
  endproperty
  a_mode: assert property (p_mode) else $error("mode settle too short");
  property p_chan;
    $rose(link_ready) |-> lat_q >= (first_q ? FIRST_CYC : CHAN_CYC);
  endproperty
  a_chan: assert property (p_chan) else $error("channel settle too short");
  property p_run_max;
    tx_active |-> run_q < 13'd5212;
  endproperty
  a_run_max: assert property (p_run_max) else $error("transmit level held too long");
  property p_run_min;
    tx_active && $past(tx_active) && tx_data_in != line_q |-> run_q >= 13'd2600;
  endproperty
  a_run_min: assert property (p_run_min) else $error("transmit line too fast");
endmodule
bind rmcs_ctrl rmcs_ctrl_sva #(.FIRST_CYC(FIRST_CYC), .CHAN_CYC(CHAN_CYC), .MODE_CYC(MODE_CYC))
  chk_u (.clk(clk), .rst(rst), .cmd_power_on(cmd_power_on), .cmd_power_off(cmd_power_off),
  .cmd_tx(cmd_tx), .link_ready(link_ready), .tx_active(tx_active), .pwr_switch(pwr_switch),
  .receive_select(receive_select), .transmit_select(transmit_select),
  .tx_data_in(tx_data_in), .pll_clk(pll_clk), .pll_data(pll_data),
  .pll_latch_strobe(pll_latch_strobe));
`default_nettype wire

/* sim/rmcs_ctrl_test.sv */
`timescale 1ns/10ps
`default_nettype none
module rmcs_ctrl_test;
  localparam int FIRST = 200;
  localparam int CHAN = 100;
  localparam int MODE = 50;
  logic clk = 1'b0;
  logic rst = 1'b1;
  // on, off, chan, tx, rx
  logic [4:0] cmd = 5'h0;
  logic [23:0] chan_word = 24'h0;
  logic tx_bit = 1'b0;
  logic tx_bit_valid = 1'b0;
  logic lock_good = 1'b1;
  logic rx_src = 1'b0;
  logic [31:0] seed = 32'h896d52d4;
  logic [3:0] bits;
  int err_count = 0;
  int comparisons = 0;
  int n;
  wire tx_bit_ready, link_ready, tx_active, lock_ok, lock_fail, cmd_err, rx_data, rx_valid;
  wire pwr_switch, receive_select, transmit_select, tx_data_in, pll_clk, pll_data;
  wire pll_latch_strobe, lock_flag, rx_data_pin, viol;
  wire [23:0] got_word;
  rmcs_ctrl #(.FIRST_CYC(FIRST), .CHAN_CYC(CHAN), .MODE_CYC(MODE), .LOCK_CYC(90)) dut_u (
    .clk(clk), .rst(rst), .cmd_power_on(cmd[0]), .cmd_power_off(cmd[1]), .cmd_chan(cmd[2]),
    .chan_word(chan_word), .cmd_tx(cmd[3]), .cmd_rx(cmd[4]), .tx_bit(tx_bit),
    .tx_bit_valid(tx_bit_valid), .tx_bit_ready(tx_bit_ready), .link_ready(link_ready),
    .tx_active(tx_active), .lock_ok(lock_ok), .lock_fail(lock_fail), .cmd_err(cmd_err),
    .rx_data(rx_data), .rx_valid(rx_valid), .pwr_switch(pwr_switch),
    .receive_select(receive_select), .transmit_select(transmit_select),
    .tx_data_in(tx_data_in), .pll_clk(pll_clk), .pll_data(pll_data),
    .pll_latch_strobe(pll_latch_strobe), .lock_flag(lock_flag), .rx_data_pin(rx_data_pin));
  // second glitch lands inside the three-sample lock filter window
  rmcs_radio_model #(.LOCK_DLY(40), .MODE_DLY(MODE), .GLITCH_AT(85)) mdl_u (
    .clk(clk), .rst(rst), .pwr_switch(pwr_switch), .receive_select(receive_select),
    .transmit_select(transmit_select), .tx_data_in(tx_data_in), .pll_clk(pll_clk),
    .pll_data(pll_data), .pll_latch_strobe(pll_latch_strobe), .lock_flag(lock_flag),
    .rx_data_pin(rx_data_pin), .lock_good(lock_good), .rx_src(rx_src), .word_q(got_word),
    .viol_q(viol));
  always #20 clk = ~clk;
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // manchester: first half carries the inverted bit, second half the bit
  function automatic logic man_lvl(input logic b, input logic second);
    return second ? b : ~b;
  endfunction
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    comparisons++;
    if (exp !== got) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // pulse one command; refusal shows on cmd_err within three cycles
  task automatic issue(input int i, input logic exp_err);
    logic seen;
    seen = 1'b0;
    @(negedge clk);
    cmd[i] = 1'b1;
    repeat (3) begin
      @(negedge clk);
      cmd[i] = 1'b0;
      seen = seen | cmd_err;
    end
    chk("cmd_err", 24'(exp_err), 24'(seen));
  endtask
  task automatic wait_link(output int cyc);
    for (cyc = 0; cyc < 3000 && link_ready !== 1'b1; cyc++)
      @(negedge clk);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #(40 * 60000);
    err_count++;
    $display("Error watchdog expected finish seen timeout");
    wrap_up();
  end
  initial begin
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    issue(2, 1'b1);
    issue(0, 1'b0);
    chk("pins on", 24'h6, 24'({pwr_switch, receive_select, transmit_select}));
    issue(3, 1'b1);
    for (int k = 0; k < 2; k++) begin
      lock_good = (k == 0);
      chan_word = 24'(xs());
      issue(2, 1'b0);
      wait_link(n);
      chk("settle", 24'h1, 24'(n + 4 >= (k ? CHAN : FIRST) && n < (k ? CHAN : FIRST) + 220));
      repeat (2) @(negedge clk);
      chk("word", chan_word, got_word);
      chk("lock", 24'({~lock_good, lock_good}), 24'({lock_fail, lock_ok}));
    end
    bits = {2'b11, 2'(xs())};
    tx_bit = bits[0];
    tx_bit_valid = 1'b1;
    issue(3, 1'b0);
    wait_link(n);
    chk("tx settle", 24'h1, 24'(n + 4 >= MODE && n < MODE + 8));
    chk("tx_active on", 24'h1, 24'(tx_active));
    fork
      for (int b = 1; b <= 4; b++) begin
        for (int w = 0; w < 6000 && tx_bit_ready !== 1'b1; w++)
          @(negedge clk);
        @(negedge clk);
        tx_bit = bits[b % 4];
        tx_bit_valid = (b < 4);
      end
      for (int b = 0; b < 4; b++) begin
        repeat (1302) @(negedge clk);
        chk("line first half", 24'(man_lvl(bits[b], 1'b0)), 24'(tx_data_in));
        repeat (2605) @(negedge clk);
        chk("line second half", 24'(man_lvl(bits[b], 1'b1)), 24'(tx_data_in));
        repeat (1303) @(negedge clk);
      end
    join
    issue(2, 1'b1);
    issue(4, 1'b0);
    wait_link(n);
    chk("rx settle", 24'h1, 24'(n + 4 >= MODE && n < MODE + 8));
    chk("tx_active off", 24'h0, 24'(tx_active));
    rx_src = xs() & 32'h1;
    repeat (6) @(negedge clk);
    chk("rx path", 24'({1'b1, rx_src}), 24'({rx_valid, rx_data}));
    chk("partner misuse", 24'h0, 24'(viol));
    issue(1, 1'b0);
    chk("pins off", 24'h0, 24'({pwr_switch, receive_select, transmit_select, tx_data_in}));
    wrap_up();
  end
endmodule
`default_nettype wire

/* sim/rmcs_radio_model.sv */
`timescale 1ns/10ps
`default_nettype none
module rmcs_radio_model #(
  parameter LOCK_DLY = 40,
  parameter MODE_DLY = 50,
  parameter GLITCH_AT = 5
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // module pins
  input wire logic pwr_switch,
  input wire logic receive_select,
  input wire logic transmit_select,
  input wire logic tx_data_in,
  input wire logic pll_clk,
  input wire logic pll_data,
  input wire logic pll_latch_strobe,
  output logic lock_flag,
  output logic rx_data_pin,
  // test controls
  input wire logic lock_good,
  input wire logic rx_src,
  output logic [23:0] word_q,
  output logic viol_q
);
  logic [23:0] sh_q;
  logic [15:0] lk_q, md_q;
  logic [1:0] sel_q;
  logic ck_q, le_q;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      {sh_q, word_q, lk_q, md_q, sel_q, ck_q, le_q, viol_q, lock_flag, rx_data_pin} <= '0;
    end else begin
      ck_q <= pll_clk;
      le_q <= pll_latch_strobe;
      sel_q <= {receive_select, transmit_select};
      if (pll_clk && !ck_q)
        sh_q <= {sh_q[22:0], pll_data};
      if (pll_latch_strobe && !le_q)
        word_q <= sh_q;
      if (((pll_clk || pll_latch_strobe) && (!pwr_switch || transmit_select))
          || (receive_select && transmit_select) || (tx_data_in && md_q < MODE_DLY))
        viol_q <= 1'b1;
      lk_q <= pll_latch_strobe ? 16'h0 : lk_q + {15'h0, ~&lk_q};
      // change is seen one cycle late, so that cycle already counts
      md_q <= ({receive_select, transmit_select} != sel_q) ? 16'h1 : md_q + {15'h0, ~&md_q};
      // one-cycle glitches at 5 and GLITCH_AT, then lock if allowed
      lock_flag <= pwr_switch && (lk_q == 16'h5 || lk_q == GLITCH_AT
                                  || (lock_good && lk_q > LOCK_DLY));
      rx_data_pin <= (receive_select && md_q >= MODE_DLY) ? rx_src : ~rx_data_pin;
    end
  end
endmodule
`default_nettype wire

/* src/rmcs_ctrl.v */
`timescale 1ns/10ps
`default_nettype none
`include "rmcs_defines.vh"

module rmcs_ctrl #(
  parameter FIRST_CYC = `RMCS_FIRST_CYC,
  parameter CHAN_CYC = `RMCS_CHAN_CYC,
  parameter MODE_CYC = `RMCS_MODE_CYC,
  parameter LOCK_CYC = `RMCS_LOCK_CYC
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // user commands
  input wire cmd_power_on,
  input wire cmd_power_off,
  input wire cmd_chan,
  input wire [`RMCS_PLL_BITS-1:0] chan_word,
  input wire cmd_tx,
  input wire cmd_rx,
  // user transmit bits
  input wire tx_bit,
  input wire tx_bit_valid,
  output reg tx_bit_ready,
  // user status
  output reg link_ready,
  output reg tx_active,
  output reg lock_ok,
  output reg lock_fail,
  output reg cmd_err,
  output reg rx_data,
  output reg rx_valid,
  // module pins
  output reg pwr_switch,
  output reg receive_select,
  output reg transmit_select,
  output reg tx_data_in,
  output wire pll_clk,
  output wire pll_data,
  output wire pll_latch_strobe,
  input wire lock_flag,
  input wire rx_data_pin
);

  localparam [3:0] S_OFF = 4'h0;
  localparam [3:0] S_RX = 4'h1;
  localparam [3:0] S_PROG = 4'h2;
  localparam [3:0] S_SETTLE = 4'h3;
  localparam [3:0] S_READY = 4'h4;
  localparam [3:0] S_TX_BRK = 4'h5;
  localparam [3:0] S_TX_SET = 4'h6;
  localparam [3:0] S_TX = 4'h7;
  localparam [3:0] S_RX_BRK = 4'h8;
  localparam [3:0] S_RX_SET = 4'h9;
  localparam integer HB_LAST_I = `RMCS_HALF_BIT_CYC - 1;
  localparam [`RMCS_HB_W-1:0] HB_LAST = HB_LAST_I[`RMCS_HB_W-1:0];

  reg [3:0] st_q;
  reg [`RMCS_CNT_W-1:0] cnt_q;
  reg first_q;
  reg [`RMCS_HB_W-1:0] hb_q;
  reg half_q;
  reg cur_q;
  reg lk_s1_q;
  reg lk_s2_q;
  reg [2:0] lk_h_q;
  reg rx_s1_q;
  reg rx_s2_q;
  wire [31:0] cnt_ext;
  wire sh_busy;
  wire sh_done;
  wire sh_start;
  wire sh_abort;
  wire acc_on;
  wire acc_off;
  wire acc_chan;
  wire acc_tx;
  wire acc_rx;
  wire any_cmd;
  wire lock_stable;
  wire settle_end;
  wire mode_end;
  wire hb_end;
  wire take;
  wire nb;

  assign cnt_ext = {{(32 - `RMCS_CNT_W){1'b0}}, cnt_q};

  // command acceptance per state; power-off overrides everything
  assign acc_on = cmd_power_on && (st_q == S_OFF);
  assign acc_off = cmd_power_off && (st_q != S_OFF);
  assign acc_chan = cmd_chan && !acc_off && ((st_q == S_RX) || (st_q == S_READY));
  assign acc_tx = cmd_tx && !acc_off && (st_q == S_READY);
  assign acc_rx = cmd_rx && !acc_off && (st_q == S_TX);
  assign any_cmd = cmd_power_on | cmd_power_off | cmd_chan | cmd_tx | cmd_rx;

  assign sh_start = acc_chan && pwr_switch;
  assign sh_abort = acc_off || !pwr_switch;

  assign settle_end = (st_q == S_SETTLE) &&
                      (cnt_ext == (first_q ? FIRST_CYC - 1 : CHAN_CYC - 1));
  assign mode_end = (cnt_ext == MODE_CYC - 1);

  // all three filtered samples must be high
  assign lock_stable = &lk_h_q;

  // half-bit period keeps line at or below 4.8 kHz
  assign hb_end = (hb_q == HB_LAST);
  assign take = ((st_q == S_TX_SET) && mode_end) || ((st_q == S_TX) && hb_end && half_q);
  // always line coded
  // idle filler zeros still toggle the line
  assign nb = tx_bit_valid ? tx_bit : 1'b0;

  rmcs_pll_shift u_shift (
    .clk(clk),
    .rst(rst),
    .start(sh_start),
    .abort(sh_abort),
    .word(chan_word),
    .busy_q(sh_busy),
    .done_q(sh_done),
    .sclk_q(pll_clk),
    .sdata_q(pll_data),
    .sle_q(pll_latch_strobe)
  );

  // pin synchronisers
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      lk_s1_q <= 1'b0;
      lk_s2_q <= 1'b0;
      lk_h_q <= 3'h0;
      rx_s1_q <= 1'b0;
      rx_s2_q <= 1'b0;
      rx_data <= 1'b0;
      rx_valid <= 1'b0;
    end else begin
      lk_s1_q <= lock_flag;
      lk_s2_q <= lk_s1_q;
      lk_h_q <= {lk_h_q[1:0], lk_s2_q};
      rx_s1_q <= rx_data_pin;
      rx_s2_q <= rx_s1_q;
      rx_data <= rx_s2_q;
      // receive data valid only after settling
      rx_valid <= (st_q == S_READY);
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      // every module pin inactive after reset
      st_q <= S_OFF;
      cnt_q <= {`RMCS_CNT_W{1'b0}};
      first_q <= 1'b1;
      hb_q <= {`RMCS_HB_W{1'b0}};
      half_q <= 1'b0;
      cur_q <= 1'b0;
      tx_bit_ready <= 1'b0;
      link_ready <= 1'b0;
      tx_active <= 1'b0;
      lock_ok <= 1'b0;
      lock_fail <= 1'b0;
      cmd_err <= 1'b0;
      pwr_switch <= 1'b0;
      receive_select <= 1'b0;
      transmit_select <= 1'b0;
      tx_data_in <= 1'b0;
    end else begin
      cmd_err <= any_cmd && !(acc_on | acc_off | acc_chan | acc_tx | acc_rx);
      tx_bit_ready <= 1'b0;
      cnt_q <= cnt_q + {{(`RMCS_CNT_W - 1){1'b0}}, 1'b1};
      if (acc_off) begin
        st_q <= S_OFF;
        pwr_switch <= 1'b0;
        receive_select <= 1'b0;
        transmit_select <= 1'b0;
        tx_data_in <= 1'b0;
        link_ready <= 1'b0;
        tx_active <= 1'b0;
        first_q <= 1'b1;
      end else begin
        case (st_q)
          S_OFF: begin
            if (acc_on) begin
              pwr_switch <= 1'b1;
              receive_select <= 1'b1;
              lock_ok <= 1'b0;
              lock_fail <= 1'b0;
              st_q <= S_RX;
            end
          end
          S_RX, S_READY: begin
            if (acc_chan) begin
              st_q <= S_PROG;
              link_ready <= 1'b0;
              lock_ok <= 1'b0;
              lock_fail <= 1'b0;
            end else if (acc_tx) begin
              receive_select <= 1'b0;
              link_ready <= 1'b0;
              st_q <= S_TX_BRK;
            end
          end
          S_PROG: begin
            if (sh_done) begin
              cnt_q <= {`RMCS_CNT_W{1'b0}};
              st_q <= S_SETTLE;
            end
          end
          S_SETTLE: begin
            if (cnt_ext == LOCK_CYC - 1) begin
              lock_ok <= lock_stable;
              lock_fail <= !lock_stable;
            end
            if (settle_end) begin
              first_q <= 1'b0;
              link_ready <= 1'b1;
              st_q <= S_READY;
            end
          end
          S_TX_BRK: begin
            transmit_select <= 1'b1;
            cnt_q <= {`RMCS_CNT_W{1'b0}};
            st_q <= S_TX_SET;
          end
          S_TX_SET: begin
            // hold data 5 ms after switching
            if (mode_end) begin
              st_q <= S_TX;
              tx_active <= 1'b1;
              link_ready <= 1'b1;
            end
          end
          S_TX: begin
            if (acc_rx) begin
              transmit_select <= 1'b0;
              tx_data_in <= 1'b0;
              tx_active <= 1'b0;
              link_ready <= 1'b0;
              st_q <= S_RX_BRK;
            end else if (hb_end && !half_q) begin
              tx_data_in <= cur_q;
            end
          end
          S_RX_BRK: begin
            receive_select <= 1'b1;
            cnt_q <= {`RMCS_CNT_W{1'b0}};
            st_q <= S_RX_SET;
          end
          S_RX_SET: begin
            // same channel, 5 ms before data
            if (mode_end) begin
              link_ready <= 1'b1;
              st_q <= S_READY;
            end
          end
          default: begin
            st_q <= S_OFF;
          end
        endcase
        // manchester half-bit timing, first half carries the inverted bit
        if (take && !acc_rx) begin
          cur_q <= nb;
          tx_data_in <= !nb;
          tx_bit_ready <= tx_bit_valid;
        end
        if (st_q == S_TX) begin
          hb_q <= hb_end ? {`RMCS_HB_W{1'b0}} : hb_q + {{(`RMCS_HB_W - 1){1'b0}}, 1'b1};
          half_q <= hb_end ? !half_q : half_q;
        end else begin
          hb_q <= {`RMCS_HB_W{1'b0}};
          half_q <= 1'b0;
        end
      end
    end
  end

endmodule
`default_nettype wire

/* src/rmcs_pll_shift.v */
`timescale 1ns/10ps
`default_nettype none
`include "rmcs_defines.vh"

module rmcs_pll_shift (
  // clock and reset
  input wire clk,
  input wire rst,
  // request
  input wire start,
  input wire abort,
  input wire [`RMCS_PLL_BITS-1:0] word,
  output reg busy_q,
  output reg done_q,
  // three-wire pins
  output reg sclk_q,
  output reg sdata_q,
  output reg sle_q
);

  localparam [1:0] P_IDLE = 2'h0;
  localparam [1:0] P_SHIFT = 2'h1;
  localparam [1:0] P_LATCH = 2'h2;
  localparam integer HALF_LAST_I = `RMCS_PLL_HALF_CYC - 1;
  localparam integer BIT_LAST_I = `RMCS_PLL_BITS - 1;
  localparam [2:0] HALF_LAST = HALF_LAST_I[2:0];
  localparam [4:0] BIT_LAST = BIT_LAST_I[4:0];

  reg [1:0] st_q;
  reg [2:0] div_q;
  reg [4:0] bit_q;
  reg [`RMCS_PLL_BITS-1:0] sh_q;
  wire tick;

  assign tick = (div_q == HALF_LAST);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= P_IDLE;
      div_q <= 3'h0;
      bit_q <= 5'h00;
      sh_q <= {`RMCS_PLL_BITS{1'b0}};
      busy_q <= 1'b0;
      done_q <= 1'b0;
      sclk_q <= 1'b0;
      sdata_q <= 1'b0;
      sle_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      div_q <= tick ? 3'h0 : div_q + 3'h1;
      // abort parks every pin low so an unpowered module is never driven
      if (abort) begin
        st_q <= P_IDLE;
        busy_q <= 1'b0;
        sclk_q <= 1'b0;
        sdata_q <= 1'b0;
        sle_q <= 1'b0;
      end else begin
        case (st_q)
          P_IDLE: begin
            if (start) begin
              st_q <= P_SHIFT;
              busy_q <= 1'b1;
              div_q <= 3'h0;
              bit_q <= 5'h00;
              sdata_q <= word[`RMCS_PLL_BITS-1];
              sh_q <= {word[`RMCS_PLL_BITS-2:0], 1'b0};
            end
          end
          // msb first, data set while clock low, taken on rising edge
          P_SHIFT: begin
            if (tick) begin
              if (!sclk_q) begin
                sclk_q <= 1'b1;
              end else begin
                sclk_q <= 1'b0;
                if (bit_q == BIT_LAST) begin
                  st_q <= P_LATCH;
                  sdata_q <= 1'b0;
                  sle_q <= 1'b1;
                end else begin
                  bit_q <= bit_q + 5'h01;
                  sdata_q <= sh_q[`RMCS_PLL_BITS-1];
                  sh_q <= {sh_q[`RMCS_PLL_BITS-2:0], 1'b0};
                end
              end
            end
          end
          P_LATCH: begin
            if (tick) begin
              sle_q <= 1'b0;
              st_q <= P_IDLE;
              busy_q <= 1'b0;
              done_q <= 1'b1;
            end
          end
          default: begin
            st_q <= P_IDLE;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire
